// File: hw/lbi_pkg.sv
`default_nettype none
package lbi_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam int REGION_W = 3;
   localparam int WAIT_W = 2;
   localparam int SIZE_SEL_W = 3;
   localparam logic [SIZE_SEL_W-1:0] SIZE_SEL_MAX = 3'h6;
   localparam int SIZE_BASE_BITS = 8;
   localparam int SIZE_STEP_BITS = 2;
   localparam int REFRESH_PERIOD_NS = 15625;
   localparam int CLK_PERIOD_NS = 25;
   localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
   localparam int REFRESH_CNT_W = 10;
   localparam logic [REFRESH_CNT_W-1:0] REFRESH_LAST =
      REFRESH_CNT_W'(REFRESH_CYCLES - 1);
   localparam logic [WAIT_W-1:0] WAIT_RESET = 2'h0;
   typedef enum logic [2:0] {
      LBI_IDLE, LBI_ADDR, LBI_ADDR_WAIT, LBI_STROBE, LBI_REFRESH,
      LBI_HOLD
   } lbi_state_e;
endpackage : lbi_pkg
`default_nettype wire

// File: hw/lbi_wait_count.sv
`default_nettype none
module lbi_wait_count (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic [lbi_pkg::WAIT_W-1:0] count_i,
   output logic done_o
);
   typedef struct packed {
      logic [lbi_pkg::WAIT_W-1:0] cnt;
   } lbi_wc_s;
   lbi_wc_s st_reg;
   lbi_wc_s st_next;
   always_comb begin
      st_next = st_reg;
      if (load_i) begin
         st_next.cnt = count_i;
      end else if (st_reg.cnt != '0) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_reg.cnt <= lbi_pkg::WAIT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end
   assign done_o = (st_reg.cnt == '0) && !load_i;
endmodule : lbi_wait_count
`default_nettype wire

// File: hw/lbi_local_bus.sv
`default_nettype none
module lbi_local_bus (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [lbi_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [lbi_pkg::DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [lbi_pkg::DATA_W-1:0] rsp_rdata_o,
   input wire logic [lbi_pkg::SIZE_SEL_W-1:0] size_sel_i,
   input wire logic [8*lbi_pkg::WAIT_W-1:0] region_wait_i,
   input wire logic address_wait_en_i,
   input wire logic pulse_refresh_en_i,
   input wire logic [7:0] refresh_region_en_i,
   input wire logic self_refresh_en_i,
   input wire logic standby_i,
   input wire logic hold_enable_i,
   output logic [lbi_pkg::ADDR_W-1:8] addr_hi_o,
   output logic addr_hi_oe_o,
   input wire logic [7:0] ad_i,
   output logic [7:0] ad_o,
   output logic ad_oe_o,
   output logic address_strobe_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic strobe_oe_o,
   output logic refresh_request_out_n_o,
   input wire logic hold_request_in_i,
   output logic hold_ack_out_o
);
   typedef struct packed {
      lbi_pkg::lbi_state_e state;
      logic [lbi_pkg::ADDR_W-1:0] addr;
      logic [lbi_pkg::REGION_W-1:0] region;
      logic [7:0] wdata;
      logic write;
      logic [7:0] rdata;
      logic rsp;
      logic [lbi_pkg::REFRESH_CNT_W-1:0] rcnt;
      logic rpend;
      logic rpulse;
      logic hold_ack;
   } lbi_bus_s;
   lbi_bus_s st_reg;
   lbi_bus_s st_next;
   logic [lbi_pkg::ADDR_W-1:0] addr_mask;
   logic [lbi_pkg::REGION_W-1:0] region;
   logic [lbi_pkg::WAIT_W-1:0] region_wait;
   logic wait_load;
   logic wait_done;
   logic refresh_allowed;
   // ==========================================================
   // Address decode
   // ==========================================================
   always_comb begin
      logic [lbi_pkg::SIZE_SEL_W-1:0] sel;
      int bits;
      sel = (size_sel_i > lbi_pkg::SIZE_SEL_MAX) ? lbi_pkg::SIZE_SEL_MAX
         : size_sel_i;
      bits = lbi_pkg::SIZE_BASE_BITS + lbi_pkg::SIZE_STEP_BITS * int'(sel);
      if (bits > lbi_pkg::ADDR_W) begin
         bits = lbi_pkg::ADDR_W;
      end
      addr_mask = lbi_pkg::ADDR_W'((64'h1 << bits) - 64'h1);
   end
   // eight logical regions
   // Region comes from the full address, not the capacity-masked one
   assign region = st_reg.region;
   assign region_wait = region_wait_i[region*lbi_pkg::WAIT_W +:
      lbi_pkg::WAIT_W];
   assign refresh_allowed = !hold_enable_i;
   // Decoded from the current state and address_wait_en_i only, so no loop via the sequencer
   assign wait_load = (st_reg.state == lbi_pkg::LBI_ADDR_WAIT) ||
      ((st_reg.state == lbi_pkg::LBI_ADDR) && !address_wait_en_i);
   lbi_wait_count u_wait (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .load_i(wait_load),
      .count_i(region_wait),
      .done_o(wait_done)
   );
   // ==========================================================
   // Bus sequencer
   // ==========================================================
   always_comb begin
      st_next = st_reg;
      st_next.rsp = 1'b0;
      st_next.rpulse = 1'b0;
      case (st_reg.state)
         lbi_pkg::LBI_IDLE: begin
            if (hold_request_in_i) begin
               st_next.state = lbi_pkg::LBI_HOLD;
            end else if (st_reg.rpend && !req_valid_i) begin
               st_next.state = lbi_pkg::LBI_REFRESH;
            end else if (req_valid_i) begin
               st_next.addr = req_addr_i & addr_mask;
               st_next.region =
                  req_addr_i[lbi_pkg::ADDR_W-1 -: lbi_pkg::REGION_W];
               st_next.wdata = req_wdata_i;
               st_next.write = req_write_i;
               st_next.state = lbi_pkg::LBI_ADDR;
            end
         end
         lbi_pkg::LBI_ADDR: begin
            st_next.state = address_wait_en_i ? lbi_pkg::LBI_ADDR_WAIT
               : lbi_pkg::LBI_STROBE;
         end
         lbi_pkg::LBI_ADDR_WAIT: begin
            st_next.state = lbi_pkg::LBI_STROBE;
         end
         lbi_pkg::LBI_STROBE: begin
            if (st_reg.rpend && refresh_region_en_i[region]) begin
               st_next.rpend = 1'b0;
               st_next.rpulse = 1'b1;
            end
            // Read data is sampled on the last strobe cycle
            if (wait_done) begin
               st_next.rdata = ad_i;
               st_next.rsp = 1'b1;
               st_next.state = lbi_pkg::LBI_IDLE;
            end
         end
         lbi_pkg::LBI_REFRESH: begin
            // Standalone cycle carrying one pulse
            st_next.rpend = 1'b0;
            st_next.rpulse = 1'b1;
            st_next.state = lbi_pkg::LBI_IDLE;
         end
         lbi_pkg::LBI_HOLD: begin
            st_next.hold_ack = hold_request_in_i;
            // Outputs stay floated until acknowledge is low
            // release before next cycle
            if (!hold_request_in_i && !st_reg.hold_ack) begin
               st_next.state = lbi_pkg::LBI_IDLE;
            end
         end
         default: begin
            st_next.state = lbi_pkg::LBI_IDLE;
         end
      endcase
      // fixed refresh interval
      // After the state clears, so a new pending request wins
      if (pulse_refresh_en_i && refresh_allowed) begin
         if (st_reg.rcnt == lbi_pkg::REFRESH_LAST) begin
            st_next.rcnt = '0;
            st_next.rpend = 1'b1;
         end else begin
            st_next.rcnt = st_reg.rcnt + 1'b1;
         end
      end else begin
         // no refresh while hold in use
         st_next.rcnt = '0;
         st_next.rpend = 1'b0;
         st_next.rpulse = 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   // ==========================================================
   // Pin drive
   // ==========================================================
   logic driving;
   logic in_strobe;
   assign driving = (st_reg.state != lbi_pkg::LBI_HOLD);
   assign in_strobe = (st_reg.state == lbi_pkg::LBI_STROBE);
   assign addr_hi_o = st_reg.addr[lbi_pkg::ADDR_W-1:8];
   assign addr_hi_oe_o = driving;
   assign strobe_oe_o = driving;
   // Low address byte first, then write data during the strobe
   assign ad_o = in_strobe ? st_reg.wdata : st_reg.addr[7:0];
   assign ad_oe_o = driving && !(in_strobe && !st_reg.write);
   assign address_strobe_o = (st_reg.state == lbi_pkg::LBI_ADDR) ||
      (st_reg.state == lbi_pkg::LBI_ADDR_WAIT);
   assign rd_n_o = !(in_strobe && !st_reg.write);
   assign wr_n_o = !(in_strobe && st_reg.write);
   // ==========================================================
   // Refresh and hold pins
   // ==========================================================
   // self-refresh level in standby
   // refresh output idle while hold in use
   assign refresh_request_out_n_o = !(refresh_allowed &&
      ((standby_i && self_refresh_en_i) || st_reg.rpulse));
   assign hold_ack_out_o = st_reg.hold_ack;
   // ==========================================================
   // Host side handshake
   // ==========================================================
   assign req_ready_o = (st_reg.state == lbi_pkg::LBI_IDLE) &&
      !hold_request_in_i && !(st_reg.rpend && !req_valid_i);
   assign rsp_valid_o = st_reg.rsp;
   assign rsp_rdata_o = st_reg.rdata;
endmodule : lbi_local_bus
`default_nettype wire

// File: verif/lbi_local_bus_asserts.sv
`default_nettype none
module lbi_local_bus_asserts (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic hold_enable_i,
   input wire logic self_refresh_en_i,
   input wire logic standby_i,
   input wire logic addr_hi_oe_o,
   input wire logic ad_oe_o,
   input wire logic address_strobe_o,
   input wire logic rd_n_o,
   input wire logic wr_n_o,
   input wire logic strobe_oe_o,
   input wire logic refresh_request_out_n_o,
   input wire logic hold_request_in_i,
   input wire logic hold_ack_out_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // ==========
   // Checks
   chk_rsp_latency: assert property (req_valid_i && req_ready_o |->
      ##[3:7] rsp_valid_o) else $error("access answer late");
   chk_strobe_end: assert property (rsp_valid_o |-> rd_n_o && wr_n_o &&
      $past(!(rd_n_o && wr_n_o))) else $error("strobe not ended");
   chk_addr_first: assert property ($fell(rd_n_o) || $fell(wr_n_o) |->
      $past(address_strobe_o)) else $error("strobe before address");
   chk_hold_float: assert property (hold_ack_out_o |-> !addr_hi_oe_o &&
      !ad_oe_o && !strobe_oe_o) else $error("bus driven in hold");
   chk_hold_refuse: assert property (hold_request_in_i |->
      !req_ready_o) else $error("access taken during hold request");
   chk_ack_float: assert property ($rose(hold_ack_out_o) |->
      $past(!strobe_oe_o)) else $error("ack before float");
   chk_ack_cause: assert property (hold_ack_out_o |->
      $past(hold_request_in_i)) else $error("ack without request");
   chk_ack_release: assert property ($fell(hold_request_in_i) &&
      hold_ack_out_o |=> !hold_ack_out_o) else $error("ack not dropped");
   chk_hold_norefr: assert property (hold_enable_i &&
      $past(hold_enable_i) |-> refresh_request_out_n_o)
      else $error("refresh with hold");
   chk_self_low: assert property (self_refresh_en_i && standby_i &&
      !hold_enable_i && $past(self_refresh_en_i && standby_i)
      |-> !refresh_request_out_n_o) else $error("self refresh high");
   chk_pulse_one: assert property (!refresh_request_out_n_o &&
      !self_refresh_en_i |=> refresh_request_out_n_o)
      else $error("refresh pulse too long");
endmodule : lbi_local_bus_asserts
bind lbi_local_bus lbi_local_bus_asserts u_chk (.*);
`default_nettype wire

// File: verif/lbi_mem_model.sv
`default_nettype none
module lbi_mem_model (
   input wire logic clk_sys_i,
   input wire logic address_strobe_o,
   input wire logic rd_n_o,
   input wire logic wr_n_o,
   input wire logic [7:0] ad_o,
   output logic [7:0] ad_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [256];
   logic [7:0] lat = 8'h00;
   logic [7:0] last = 8'h00;
   always_ff @(posedge clk_sys_i) begin
      if (address_strobe_o) lat <= ad_o;
      if (!wr_n_o) mem[lat] <= ad_o;
      if (!rd_n_o) last <= mem[lat];
   end
   // Released bus shows the inverse of the last byte
   assign ad_i = rd_n_o ? ~last : mem[lat];
endmodule : lbi_mem_model
`default_nettype wire

// File: verif/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys_i, reset_i, req_valid_i, req_write_i, req_ready_o;
   logic rsp_valid_o, address_wait_en_i, pulse_refresh_en_i, standby_i;
   logic self_refresh_en_i, hold_enable_i, addr_hi_oe_o, ad_oe_o, rd_n_o;
   logic address_strobe_o, wr_n_o, strobe_oe_o, refresh_request_out_n_o;
   logic hold_request_in_i, hold_ack_out_o;
   logic [19:0] req_addr_i;
   logic [7:0] req_wdata_i, rsp_rdata_o, refresh_region_en_i, ad_i, ad_o;
   logic [2:0] size_sel_i;
   logic [15:0] region_wait_i;
   logic [19:8] addr_hi_o;
   int fails = 0, num_checks = 0, cyc = 0;
   int hidden = 0, pulses = 0;
   lbi_local_bus u_dut (.*);
   lbi_mem_model u_mem (.*);
   initial begin
      clk_sys_i = 0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         fails++;
         stop_test();
      end
   end
   // Refresh pulses, and those that fall inside a strobe
   always @(negedge clk_sys_i) begin
      pulses += !refresh_request_out_n_o;
      hidden += !refresh_request_out_n_o && !(rd_n_o && wr_n_o);
   end
   // ==========
   // Helpers
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic access(input logic wr, input logic [19:0] a,
         input logic [7:0] d, input int lat, input int bits);
      int n;
      logic [19:8] hi;
      @(posedge clk_sys_i);
      req_valid_i <= 1;
      req_write_i <= wr;
      req_addr_i <= a;
      req_wdata_i <= d;
      n = 0;
      do @(negedge clk_sys_i); while (req_ready_o !== 1'b1 && ++n < 50);
      @(posedge clk_sys_i);
      req_valid_i <= 0;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
         if (n == 1) hi = addr_hi_o;
         if (n == 1) chk(ad_o, a[7:0]);
      end while (rsp_valid_o !== 1'b1 && n < 20);
      chk(n, lat);
      chk(hi, (a & (20'hFFFFF >> (20 - bits))) >> 8);
      if (!wr) chk(rsp_rdata_o, d);
   endtask : access
   // ==========
   // Scenarios
   task automatic t_regions();
      for (int r = 0; r < 8; r++) begin
         @(posedge clk_sys_i);
         address_wait_en_i <= r[0];
         size_sel_i <= 3'(r);
         access(1, {3'(r), 9'h1A5, 3'(r), 5'h11}, 8'hC3 ^ 8'(r),
            3 + r % 2 + r % 4, 8 + 2 * (r > 6 ? 6 : r));
         access(0, {3'(r), 9'h1A5, 3'(r), 5'h11}, 8'hC3 ^ 8'(r),
            3 + r % 2 + r % 4, 8 + 2 * (r > 6 ? 6 : r));
      end
   endtask : t_regions
   task automatic t_hold();
      int n;
      @(posedge clk_sys_i);
      hold_request_in_i <= 1;
      n = 0;
      do @(negedge clk_sys_i); while (hold_ack_out_o !== 1'b1 && ++n < 10);
      chk(hold_ack_out_o, 1);
      chk({addr_hi_oe_o, ad_oe_o, strobe_oe_o, req_ready_o}, 0);
      @(posedge clk_sys_i);
      hold_request_in_i <= 0;
      repeat (3) @(negedge clk_sys_i);
      chk(hold_ack_out_o, 0);
      access(0, 20'hE0011, 8'hC3, 7, 20);
   endtask : t_hold
   task automatic t_refresh(input logic hold, input int exp);
      int seen;
      @(posedge clk_sys_i);
      pulse_refresh_en_i <= 1;
      hold_enable_i <= hold;
      seen = 0;
      // Window covers one interval plus the standalone cycle
      repeat (630) @(negedge clk_sys_i) seen += !refresh_request_out_n_o;
      chk(seen, exp);
      @(posedge clk_sys_i);
      pulse_refresh_en_i <= 0;
      hold_enable_i <= 0;
   endtask : t_refresh
   task automatic t_self();
      @(posedge clk_sys_i);
      self_refresh_en_i <= 1;
      standby_i <= 1;
      repeat (3) @(negedge clk_sys_i);
      chk(refresh_request_out_n_o, 0);
      @(posedge clk_sys_i);
      self_refresh_en_i <= 0;
      standby_i <= 0;
   endtask : t_self
   task automatic t_hidden();
      int h0;
      int p0;
      @(posedge clk_sys_i);
      pulse_refresh_en_i <= 1;
      h0 = hidden;
      p0 = pulses;
      // Back-to-back accesses; the pending refresh lands in one of them
      repeat (80) access(0, 20'hE0011, 8'hC3, 7, 20);
      chk(hidden - h0, 1);
      chk(pulses - p0, 1);
      @(posedge clk_sys_i);
      pulse_refresh_en_i <= 0;
   endtask : t_hidden
   task automatic stop_test();
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   initial begin
      {req_valid_i, req_write_i, address_wait_en_i, pulse_refresh_en_i} = 0;
      {standby_i, self_refresh_en_i, hold_enable_i, hold_request_in_i} = 0;
      {req_addr_i, req_wdata_i, size_sel_i, refresh_region_en_i} = 0;
      region_wait_i = 16'hE4E4;
      reset_i = 1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 0;
      t_regions();
      t_hold();
      @(posedge clk_sys_i);
      refresh_region_en_i <= 8'hFF;
      t_hidden();
      t_refresh(0, 1);
      t_refresh(1, 0);
      t_self();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
